// file: cfx_data_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cfx_data_if;
  logic [11:0] addr;
  logic [7:0]  rdata;
  logic [7:0]  wdata;
  logic        we;

  modport core
  (
    output addr,
    output wdata,
    output we,
    input  rdata
  );
  modport mem
  (
    input  addr,
    input  wdata,
    input  we,
    output rdata
  );
endinterface
`default_nettype wire

// file: cfx_exec.sv
// Overview of operation
// - invert-file opcode 0001 11da: read file register, invert all bits
// - dest bit 1 writes accumulator, dest bit 0 writes back to file
// - access bit 0 uses access bank; 1 uses bank select register
// - access 0, extended set on, address <= 95: indexed literal offset
// - compare opcode 0110 001a: unsigned subtract file minus W, no write
// - equal compare discards next fetched word, one no-op cycle
// - discarded two-word instruction costs two no-op cycles, three total
`timescale 1ns/1ns
`default_nettype none
module cfx_exec
  import cfx_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [15:0] instr_word,
  input  wire logic       instr_valid,
  input  wire logic [15:0] next_word,
  input  wire logic [3:0] bank_select_reg,
  input  wire logic [7:0] index_base,
  input  wire logic       extended_en,
  output logic [7:0]      accum,
  output logic            flag_negative,
  output logic            flag_zero,
  output logic            instr_done,
  output logic            skip_active,
  output logic [1:0]      phase
);

  ////////////////////////////////////////////////////////////////////////
  // decode

  cfx_data_if data_bus ();

  cfx_file_mem #(
    .ADDR_W (ADDR_W)
  ) u_mem (
    .core_clk (core_clk),
    .port     (data_bus)
  );

  cfx_phase_type   q_phase;
  cfx_phase_type   next_q_phase;
  logic [15:0]     held_word;
  logic [1:0]      skip_left;
  logic [11:0]     eff_addr;
  logic            busy;

  function automatic logic is_two_word(input logic [15:0] w);
    return (w[15:12] == CFX_CALL_NIB && w[11:9] == 3'h6)
        || (w[15:12] == CFX_MOVFF_NIB)
        || (w[15:12] == CFX_CALL_NIB && w[11:8] == CFX_TWO_WORD_NIB);
  endfunction

  wire [7:0] f_field   = held_word[7:0];
  wire       access_a  = held_word[CFX_ACCESS_BIT];
  wire       dest_d    = held_word[CFX_DEST_BIT];
  wire       is_invert =
    held_word[CFX_OPC_HI:CFX_INV_OPC_LO] == CFX_OPC_INVERT;
  wire       is_cmpeq  =
    held_word[CFX_OPC_HI:CFX_CMP_OPC_LO] == CFX_OPC_CMPEQ;
  wire       indexed   = !access_a && extended_en
                         && (f_field <= CFX_INDEXED_MAX);
  wire [7:0] idx_sum   = index_base + f_field;
  wire [11:0] access_addr = (f_field < CFX_ACCESS_SPLIT)
                         ? {4'h0, f_field}
                         : {CFX_ACCESS_HIBNK, f_field};
  wire [11:0] next_eff_addr =
      indexed  ? {4'h0, idx_sum}
    : access_a ? {bank_select_reg, f_field}
    :            access_addr;
  wire [7:0] inverted  = ~data_bus.rdata;
  wire [8:0] diff      = {1'b0, data_bus.rdata} - {1'b0, accum};
  wire       equal     = diff == 9'h000;
  wire       in_write  = busy && q_phase == CFX_PH_WRITE;
  wire       start     = instr_valid && !busy && skip_left == 2'h0;

  assign next_q_phase = cfx_phase_type'(q_phase + 2'h1);
  assign phase        = q_phase;
  assign skip_active  = skip_left != 2'h0;

  // write-back to the file only for invert with dest 0
  assign data_bus.addr  = eff_addr;
  assign data_bus.wdata = inverted;
  assign data_bus.we    = in_write && is_invert && !dest_d;

  ////////////////////////////////////////////////////////////////////////
  // quarter-phase sequencer

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      q_phase <= CFX_PH_DECODE;
    else
      q_phase <= next_q_phase;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      busy      <= 1'b0;
      held_word <= 16'h0000;
      eff_addr  <= 12'h000;
    end
    else if (q_phase == CFX_PH_DECODE && start)
    begin
      busy      <= 1'b1;
      held_word <= instr_word;
    end
    else if (q_phase == CFX_PH_READ)
      eff_addr  <= next_eff_addr;
    else if (in_write)
      busy      <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // results, flags and skip

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      accum         <= CFX_RESET_BYTE;
      flag_negative <= 1'b0;
      flag_zero     <= 1'b0;
      skip_left     <= 2'h0;
      instr_done    <= 1'b0;
    end
    else
    begin
      instr_done <= in_write;
      if (in_write && is_invert)
      begin
        if (dest_d)
          accum <= inverted;
        flag_negative <= inverted[CFX_SIGN_BIT];
        flag_zero     <= inverted == 8'h00;
      end
      // compare touches no flag and writes nothing
      if (in_write && is_cmpeq && equal)
        skip_left <= is_two_word(next_word) ? CFX_SKIP_TWO
                                            : CFX_SKIP_ONE;
      else if (q_phase == CFX_PH_WRITE && skip_left != 2'h0)
        skip_left <= skip_left - 2'h1;
    end
  end

endmodule
`default_nettype wire

// file: cfx_exec_props.sv
`timescale 1ns/1ns
`default_nettype none
module cfx_exec_props
  import cfx_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       instr_valid,
  input wire logic [7:0] accum,
  input wire logic       flag_negative,
  input wire logic       flag_zero,
  input wire logic       instr_done,
  input wire logic       skip_active,
  input wire logic [1:0] phase
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_nop4; skip_active [*4]; endsequence
  property p_take; instr_done |-> $past(instr_valid, 4); endproperty
  a_take: assert property (p_take) else $error("done without take");
  property p_acc; $changed(accum) |-> instr_done; endproperty
  a_acc: assert property (p_acc) else $error("stray accum");
  property p_flg; $changed({flag_negative, flag_zero}) |-> instr_done;
  endproperty
  a_flg: assert property (p_flg) else $error("stray flags");
  property p_nz; !(flag_negative && flag_zero); endproperty
  a_nz: assert property (p_nz) else $error("flags clash");
  property p_sk; $rose(skip_active) |-> instr_done ##0 s_nop4; endproperty
  a_sk: assert property (p_sk) else $error("bad skip");
  property p_sk8; skip_active [*8] |=> !skip_active; endproperty
  a_sk8: assert property (p_sk8) else $error("long skip");
  property p_nop; $past(skip_active) && skip_active |-> !instr_done;
  endproperty
  a_nop: assert property (p_nop) else $error("work in skip");
  property p_ph; phase == CFX_PH_WRITE |=> phase == CFX_PH_DECODE;
  endproperty
  a_ph: assert property (p_ph) else $error("phase order");
endmodule
bind cfx_exec cfx_exec_props u_props (.*);
`default_nettype wire

// file: cfx_file_mem.sv
`timescale 1ns/1ns
`default_nettype none
module cfx_file_mem
  import cfx_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic core_clk,
  cfx_data_if.mem   port
);
  logic [7:0] store [2**ADDR_W];

  // power-up contents are zero; an unwritten location would otherwise
  // read back unknown and poison both the invert result and the compare
  initial
  begin
    foreach (store[j])
      store[j] = CFX_RESET_BYTE;
  end

  // registered read: data valid one quarter-phase after the address
  always_ff @(posedge core_clk)
  begin
    if (port.we)
      store[port.addr] <= port.wdata;
    port.rdata <= store[port.addr];
  end
endmodule
`default_nettype wire

// file: cfx_pkg.sv
package cfx_pkg;

  // opcode fields
  localparam logic [5:0] CFX_OPC_INVERT   = 6'h07;
  localparam logic [6:0] CFX_OPC_CMPEQ    = 7'h31;
  localparam int         CFX_OPC_HI       = 15;
  localparam int         CFX_INV_OPC_LO   = 10;
  localparam int         CFX_CMP_OPC_LO   = 9;
  localparam int         CFX_DEST_BIT     = 9;
  localparam int         CFX_ACCESS_BIT   = 8;
  localparam logic [7:0] CFX_INDEXED_MAX  = 8'h5f;
  localparam logic [7:0] CFX_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] CFX_ACCESS_HIBNK = 4'hf;
  localparam int         CFX_SIGN_BIT     = 7;

  // two-word instructions begin with 1111 in the second word; the first
  // word of such an instruction has top nibble CFX_MOVFF_NIB, or top nibble CFX_CALL_NIB with bits 11:9 = 110 or with CFX_TWO_WORD_NIB in bits 11:8
  localparam logic [3:0] CFX_TWO_WORD_NIB = 4'hf;
  localparam logic [3:0] CFX_CALL_NIB     = 4'he;
  localparam logic [3:0] CFX_MOVFF_NIB    = 4'hc;

  localparam logic [7:0] CFX_RESET_BYTE   = 8'h00;
  localparam logic [1:0] CFX_SKIP_ONE     = 2'h1;
  localparam logic [1:0] CFX_SKIP_TWO     = 2'h2;

  typedef enum logic [1:0] {
    CFX_PH_DECODE,
    CFX_PH_READ,
    CFX_PH_PROCESS,
    CFX_PH_WRITE
  } cfx_phase_type;

endpackage

// file: tb_cfx_exec.sv
`timescale 1ns/1ns
`default_nettype none
module tb_cfx_exec;
  import cfx_pkg::*;
  logic core_clk = 0, resetn = 0, instr_valid = 0, extended_en = 0;
  logic [15:0] instr_word = 0, next_word = 0, w;
  logic [3:0] bank_select_reg = 0;
  logic [7:0] index_base = 0, accum, acc = 0, m [4096];
  logic flag_negative, flag_zero, instr_done, skip_active, n = 0, z = 0;
  logic [1:0] phase;
  int errors = 0, samples_checked = 0, k;
  logic [15:0] tab [4] = '{16'hec00, 16'hc123, 16'hef00, 16'hf000};
  always #2 core_clk = ~core_clk;
  cfx_exec dut (.core_clk(core_clk), .resetn(resetn),
    .instr_word(instr_word), .instr_valid(instr_valid),
    .next_word(next_word), .bank_select_reg(bank_select_reg),
    .index_base(index_base), .extended_en(extended_en), .accum(accum),
    .flag_negative(flag_negative), .flag_zero(flag_zero),
    .instr_done(instr_done), .skip_active(skip_active), .phase(phase));
  task conclude;
    $display("errors=%0d checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  function logic [11:0] fa(input logic [15:0] i);
    if (i[8]) return {bank_select_reg, i[7:0]};
    if (extended_en && i[7:0] <= CFX_INDEXED_MAX)
      return {4'h0, i[7:0] + index_base};
    return {i[7:0] < CFX_ACCESS_SPLIT ? 4'h0 : CFX_ACCESS_HIBNK, i[7:0]};
  endfunction
  // inputs move only at falling edges; phase seen here holds at next rise
  task run(input logic [15:0] i, nw);
    logic [11:0] ad;
    logic [7:0] r, e;
    int c;
    ad = fa(i);
    r = ~m[ad];
    e = 0;
    if (m[ad] == acc)
      e = (nw[15:9] == 7'h76 || nw[15:12] == 4'hc || nw[15:8] == 8'hef) ? 8 : 4;
    instr_word = i;
    next_word = nw;
    instr_valid = 1;
    for (c = 0; (phase !== 0 || skip_active !== 0) && c < 20; c++)
      @(negedge core_clk);
    if (c >= 20)
    begin
      errors++;
      $display("Error %0t: instruction never taken", $time);
      conclude;
    end
    @(negedge core_clk);
    instr_valid = 0;
    for (c = 0; instr_done !== 1'b1; c++)
    begin
      if (c > 9)
      begin
        errors++;
        conclude;
      end
      @(negedge core_clk);
    end
    if (i[15:10] == CFX_OPC_INVERT)
    begin
      if (i[9]) acc = r;
      else m[ad] = r;
      n = r[7];
      z = r == 0;
    end
    else
    begin
      for (c = 0; skip_active === 1'b1 && c < 12; c++)
        @(negedge core_clk);
      chk(c[7:0], e);
    end
    chk(accum, acc);
    chk({6'h0, flag_negative, flag_zero}, {6'h0, n, z});
  endtask
  initial
  begin
    foreach (m[j]) m[j] = CFX_RESET_BYTE;
    k = $urandom(32'h17869b47);
    repeat (6) @(negedge core_clk);
    resetn = 1;
    run(16'h1e05, 16'h0000);
    run(16'h6205, 16'hec00);
    run(16'h1c05, 16'h0000);
    run(16'h6205, 16'hec00);
    run(16'h6205, 16'h1234);
    repeat (300)
    begin
      bank_select_reg = $urandom;
      extended_en = $urandom;
      index_base = $urandom & 8'h7f;
      w = $urandom;
      if (w[14]) w[15:9] = CFX_OPC_CMPEQ;
      else w[15:10] = CFX_OPC_INVERT;
      w[7:0] = w[7:0] & 8'hc3;
      run(w, tab[$urandom % 4]);
    end
    conclude;
  end
endmodule
`default_nettype wire
